// ==== rst_seq_regs.svh ====
`ifndef RST_SEQ_REGS_SVH
`define RST_SEQ_REGS_SVH

// Byte offset of the reset cause and control register
`define RCC_OFFSET 8'h00
// Byte offset of the sequencer status register
`define SEQ_STATUS_OFFSET 8'h04

// Field positions in reset_cause_control
`define BIT_TRAP 15
`define BIT_ILLEGAL 14
`define BIT_MISMATCH 9
`define BIT_REG_SLEEP 8
`define BIT_MCLR 7
`define BIT_SOFT 6
`define BIT_WDT_EN 5
`define BIT_WDT_TO 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWNOUT 1
`define BIT_POWERON 0

// Writable bits; 13..10 are unimplemented
`define RCC_MASK 16'hc3ff
// Value after power-on
`define RCC_POR_VALUE 16'h0003

// Clock rate and delays
`define CLK_MHZ 50
`define T_POR_US 30
`define T_BOR_US 100
`define T_LOCK_US 1500
`define T_CLOCK_FAIL_MONITOR_US 900
`define T_OST_PERIODS 1024
`define T_POR_CYC (`T_POR_US * `CLK_MHZ)
`define T_BOR_CYC (`T_BOR_US * `CLK_MHZ)
`define T_LOCK_CYC (`T_LOCK_US * `CLK_MHZ)
`define T_CLOCK_FAIL_MONITOR_CYC (`T_CLOCK_FAIL_MONITOR_US * `CLK_MHZ)
// One millisecond in clock cycles, base unit of the power-up timer
`define MS_CYC (1000 * `CLK_MHZ)

// Reset vector
`define RESET_VECTOR 24'h000000

`endif

// ==== rst_seq_pkg.sv ====
package rst_seq_pkg;

    typedef enum logic [2:0] {
        OSC_FRC,
        OSC_FRCPLL,
        OSC_XT,
        OSC_HS,
        OSC_EC,
        OSC_XTPLL,
        OSC_HSPLL,
        OSC_ECPLL
    } clock_mode_e;

    // Reset requests from the surrounding logic, one bit per cause
    typedef struct packed {
        logic trap_conflict;
        logic illegal_condition;
        logic config_mismatch;
        logic master_clear;
        logic soft_reset;
        logic watchdog_timeout;
    } reset_events_s;

    // Fuse settings seen by the sequencer
    typedef struct packed {
        logic watchdog_fuse_enable;
        logic [2:0] power_up_timer;
        logic [2:0] initial_clock_select_fuse;
    } fuses_s;

endpackage : rst_seq_pkg

// ==== reset_cause_and_startup_sequencer.sv ====
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`include "rst_seq_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module reset_cause_and_startup_sequencer #(
    parameter int unsigned MS_CYCLES = `MS_CYC,
    parameter int unsigned LOCK_CYCLES = `T_LOCK_CYC,
    parameter int unsigned CLOCK_FAIL_MONITOR_CYCLES = `T_CLOCK_FAIL_MONITOR_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Supply monitors, active while supply is below threshold
    input wire logic por_below,
    input wire logic bor_below,
    // Reset sources and power mode events
    input wire rst_seq_pkg::reset_events_s events,
    input wire logic sleep_entry,
    input wire logic idle_entry,
    input wire rst_seq_pkg::fuses_s fuses,
    input wire rst_seq_pkg::clock_mode_e current_clock_select,
    input wire logic fail_monitor_enable,
    // One pulse per oscillator period while starting up
    input wire logic osc_tick,
    output logic system_reset,
    output logic clock_ready,
    output rst_seq_pkg::clock_mode_e selected_clock,
    output logic [23:0] fetch_address,
    output logic fetch_start,
    output logic watchdog_enable,
    output logic regulator_active_in_sleep,
    output logic clock_fail_monitor_active
);
    import rst_seq_pkg::*;

    typedef enum logic [2:0] {
        ST_POR,
        ST_BOR,
        ST_POWER_UP_TIMER,
        ST_OST,
        ST_LOCK,
        ST_RUN
    } seq_state_e;

    // Power-up timer settings: 0,2,4,8,16,32,64,128 ms style ladder of eight
    function automatic logic [7:0] power_up_timer_ms(input logic [2:0] sel);
        power_up_timer_ms = (sel == 3'd0) ? 8'h00 : 8'h01 << (sel);
    endfunction : power_up_timer_ms

    function automatic logic uses_ost(input clock_mode_e m);
        uses_ost = (m == OSC_XT) || (m == OSC_HS) || (m == OSC_XTPLL) || (m == OSC_HSPLL);
    endfunction : uses_ost

    function automatic logic uses_pll(input clock_mode_e m);
        uses_pll = (m == OSC_FRCPLL) || (m == OSC_XTPLL) || (m == OSC_HSPLL) || (m == OSC_ECPLL);
    endfunction : uses_pll

    // Supply comparators are asynchronous: two-stage synchronisers
    logic [1:0] por_sync;
    logic [1:0] bor_sync;
    logic [1:0] mclr_sync;
    logic por_low;
    logic bor_low;
    logic mclr_low;

    always_ff @(posedge aclk) begin
        por_sync <= {por_sync[0], por_below};
        bor_sync <= {bor_sync[0], bor_below};
        mclr_sync <= {mclr_sync[0], events.master_clear};
    end

    assign por_low = por_sync[1];
    assign bor_low = bor_sync[1];
    assign mclr_low = mclr_sync[1];

    seq_state_e state;
    seq_state_e next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic [15:0] rcc;
    logic [15:0] next_rcc;
    logic cold_seen;
    logic clock_fail_monitor_wait;
    logic [31:0] clock_fail_monitor_count;

    // Warm sources, ORed into one level request with no one-shot filtering
    wire logic warm_event = events.trap_conflict | events.illegal_condition |
                            events.config_mismatch | mclr_low |
                            events.soft_reset | events.watchdog_timeout;
    wire logic cold_event = por_low | bor_low;
    wire clock_mode_e boot_mode = clock_mode_e'(fuses.initial_clock_select_fuse);
    wire logic [31:0] power_up_timer_cycles = 32'(power_up_timer_ms(fuses.power_up_timer)) * MS_CYCLES;

    // Bus decode
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire logic do_write = aw_held && w_held && !s_axi_bvalid;
    wire logic wr_rcc = do_write && (aw_addr == `RCC_OFFSET);
    wire logic wr_hit = wr_rcc || (do_write && aw_addr == `SEQ_STATUS_OFFSET);
    wire logic do_read = s_axi_arvalid && s_axi_arready;
    wire logic rd_rcc = s_axi_araddr == `RCC_OFFSET;
    wire logic rd_stat = s_axi_araddr == `SEQ_STATUS_OFFSET;
    wire logic [15:0] strb_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    wire logic [15:0] stat_word = {8'h00, clock_fail_monitor_active, clock_ready,
                                   system_reset, 2'b00, 3'(state)};

    // Sequencer
    always_comb begin
        next_state = state;
        next_count = count + 32'd1;
        case (state)
            ST_POR: begin
                if (por_low) begin
                    next_count = 32'd0;
                end else if (count >= `T_POR_CYC) begin
                    next_state = ST_BOR;
                    next_count = 32'd0;
                end
            end
            ST_BOR: begin
                if (bor_low) begin
                    next_count = 32'd0;
                end else if (count >= `T_BOR_CYC) begin
                    next_state = ST_POWER_UP_TIMER;
                    next_count = 32'd0;
                end
            end
            ST_POWER_UP_TIMER: begin
                if (!cold_seen || count >= power_up_timer_cycles) begin
                    next_state = ST_OST;
                    next_count = 32'd0;
                end
            end
            ST_OST: begin
                next_count = count;
                if (!uses_ost(selected_clock) || count >= `T_OST_PERIODS) begin
                    next_state = ST_LOCK;
                    next_count = 32'd0;
                end else if (osc_tick) begin
                    next_count = count + 32'd1;
                end
            end
            ST_LOCK: begin
                if (!uses_pll(selected_clock) || count >= LOCK_CYCLES) begin
                    next_state = ST_RUN;
                    next_count = 32'd0;
                end
            end
            ST_RUN: begin
                next_count = 32'd0;
            end
            default: begin
                next_state = ST_POR;
                next_count = 32'd0;
            end
        endcase
        if (por_low) begin
            next_state = ST_POR;
            next_count = 32'd0;
        end else if (bor_low) begin
            next_state = ST_BOR;
            next_count = 32'd0;
        end else if (warm_event && state == ST_RUN) begin
            next_state = ST_POWER_UP_TIMER;
            next_count = 32'd0;
        end
    end

    // Flag register
    always_comb begin
        next_rcc = rcc;
        if (wr_rcc) begin
            next_rcc = (rcc & ~strb_mask) | (w_data[15:0] & strb_mask);
        end
        if (events.trap_conflict) next_rcc[`BIT_TRAP] = 1'b1;
        if (events.illegal_condition) next_rcc[`BIT_ILLEGAL] = 1'b1;
        if (events.config_mismatch) next_rcc[`BIT_MISMATCH] = 1'b1;
        if (mclr_low) next_rcc[`BIT_MCLR] = 1'b1;
        if (events.soft_reset) next_rcc[`BIT_SOFT] = 1'b1;
        if (events.watchdog_timeout) next_rcc[`BIT_WDT_TO] = 1'b1;
        if (sleep_entry) next_rcc[`BIT_SLEEP] = 1'b1;
        if (idle_entry) next_rcc[`BIT_IDLE] = 1'b1;
        if (bor_low) next_rcc[`BIT_BROWNOUT] = 1'b1;
        if (por_low) next_rcc = `RCC_POR_VALUE;
        next_rcc = next_rcc & `RCC_MASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_POR;
            count <= 32'd0;
            rcc <= `RCC_POR_VALUE;
            cold_seen <= 1'b1;
        end else begin
            state <= next_state;
            count <= next_count;
            rcc <= next_rcc;
            if (cold_event) begin
                cold_seen <= 1'b1;
            end else if (next_state == ST_RUN) begin
                cold_seen <= 1'b0;
            end
        end
    end

    // Outputs and clock selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            system_reset <= 1'b1;
            clock_ready <= 1'b0;
            selected_clock <= OSC_FRC;
            fetch_address <= 24'h000000;
            fetch_start <= 1'b0;
            watchdog_enable <= 1'b1;
            regulator_active_in_sleep <= 1'b0;
        end else begin
            system_reset <= (next_state == ST_POR) || (next_state == ST_BOR) ||
                            (next_state == ST_POWER_UP_TIMER);
            clock_ready <= next_state == ST_RUN;
            // cold picks fuses; warm keeps current
            if (state == ST_POWER_UP_TIMER && next_state == ST_OST) begin
                selected_clock <= cold_seen ? boot_mode : current_clock_select;
            end
            fetch_start <= (next_state == ST_RUN) && (state != ST_RUN);
            fetch_address <= `RESET_VECTOR;
            watchdog_enable <= fuses.watchdog_fuse_enable | rcc[`BIT_WDT_EN];
            regulator_active_in_sleep <= rcc[`BIT_REG_SLEEP];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN) begin
            clock_fail_monitor_count <= 32'd0;
            clock_fail_monitor_wait <= 1'b1;
            clock_fail_monitor_active <= 1'b0;
        end else begin
            if (clock_fail_monitor_wait) begin
                clock_fail_monitor_count <= clock_fail_monitor_count + 32'd1;
                clock_fail_monitor_wait <= clock_fail_monitor_count < CLOCK_FAIL_MONITOR_CYCLES - 1;
            end
            clock_fail_monitor_active <= fail_monitor_enable && !clock_fail_monitor_wait;
        end
    end

    // AXI4-Lite write path
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path; unmapped reads answer SLVERR with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !do_read;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_rcc ? {16'h0000, rcc} :
                               rd_stat ? {16'h0000, stat_word} : 32'h00000000;
                s_axi_rresp <= (rd_rcc || rd_stat) ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : reset_cause_and_startup_sequencer

`default_nettype wire

// ==== rst_seq_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module rst_seq_assertions #(
    parameter int unsigned CLOCK_FAIL_MONITOR_CYCLES = 15
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic bor_below,
    input wire rst_seq_pkg::reset_events_s events,
    input wire rst_seq_pkg::fuses_s fuses,
    input wire logic fail_monitor_enable,
    input wire logic system_reset,
    input wire logic clock_ready,
    input wire logic [23:0] fetch_address,
    input wire logic fetch_start,
    input wire logic watchdog_enable,
    input wire logic clock_fail_monitor_active
);
    import rst_seq_pkg::*;
    localparam int CLOCK_FAIL_MONITOR_LO = CLOCK_FAIL_MONITOR_CYCLES - 1;
    localparam int CLOCK_FAIL_MONITOR_HI = CLOCK_FAIL_MONITOR_CYCLES + 3;
    logic [7:0] rd_addr;
    int unsigned ready_cnt;
    // Address of the read in flight, so read data can be judged by target
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_addr <= 8'h00;
            ready_cnt <= 0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) rd_addr <= s_axi_araddr;
            ready_cnt <= clock_ready ? ready_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rsvd_bits_zero: assert property (
        s_axi_rvalid && rd_addr == 8'h00 |-> (s_axi_rdata & 32'hffff3c00) == 32'h0)
        else $error("reserved control bits read nonzero");
    chk_unmapped_slverr: assert property (
        s_axi_rvalid && rd_addr > 8'h04 |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response changed before taken");
    chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed before taken");
    chk_wdt_fuse_on: assert property (
        fuses.watchdog_fuse_enable |=> watchdog_enable)
        else $error("watchdog off while fuse forces it on");
    chk_warm_cause_rst: assert property (
        (|events) && clock_ready |-> ##[1:4] system_reset)
        else $error("reset cause did not raise system reset");
    chk_brownout_rst: assert property (
        bor_below |-> ##[1:4] system_reset)
        else $error("low supply did not hold system reset");
    chk_ready_no_rst: assert property (
        clock_ready |-> !system_reset)
        else $error("clock ready while system reset held");
    chk_fetch_vector: assert property (
        fetch_start |-> clock_ready && fetch_address == 24'h000000 ##1 !fetch_start)
        else $error("fetch start not a single pulse at reset vector");
    chk_monitor_start: assert property (
        $rose(clock_ready) && fail_monitor_enable |-> ##[CLOCK_FAIL_MONITOR_LO:CLOCK_FAIL_MONITOR_HI] clock_fail_monitor_active)
        else $error("fail monitor did not start after its delay");
    chk_monitor_early: assert property (
        clock_fail_monitor_active |-> ready_cnt >= CLOCK_FAIL_MONITOR_LO)
        else $error("fail monitor active too early");
endmodule : rst_seq_assertions
`default_nettype wire

// ==== supply_osc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module supply_osc_model (
    input wire logic aclk,
    input wire logic power_cut,
    input wire logic brown_cut,
    input wire logic [3:0] tick_div,
    input wire logic system_reset,
    output logic por_below,
    output logic bor_below,
    output var logic osc_tick
);
    logic [3:0] div_cnt = 4'h0;
    // below the power-on level is below brown-out too
    assign por_below = power_cut;
    assign bor_below = power_cut | brown_cut;
    // oscillator only runs once system reset is released
    always_ff @(posedge aclk) begin
        if (system_reset) begin
            div_cnt <= 4'h0;
            osc_tick <= 1'b0;
        end else begin
            div_cnt <= (div_cnt == tick_div - 4'h1) ? 4'h0 : div_cnt + 4'h1;
            osc_tick <= (div_cnt == tick_div - 4'h1);
        end
    end
endmodule : supply_osc_model
`default_nettype wire

// ==== reset_cause_and_startup_sequencer_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module reset_cause_and_startup_sequencer_tb;
    import rst_seq_pkg::*;
    localparam int MS_C = 10;
    localparam int LOCK_C = 20;
    localparam int flag_pos [6] = '{15, 14, 9, 7, 6, 4};
    logic aclk = 1'b0, aresetn = 1'b0, power_cut = 1'b1, brown_cut = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_entry = 1'b0, idle_entry = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] tick_div = 4'h2;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic por_below, bor_below, osc_tick, system_reset, clock_ready, fetch_start;
    logic watchdog_enable, regulator_active_in_sleep, clock_fail_monitor_active;
    logic [23:0] fetch_address;
    reset_events_s events = '0;
    fuses_s fuses = '{1'b0, 3'd2, OSC_HS};
    clock_mode_e current_clock_select = OSC_FRC, selected_clock;
    int n_fail = 0, n_tests = 0;
    logic [15:0] rnd = 16'h0027;
    reset_cause_and_startup_sequencer #(.MS_CYCLES(MS_C), .LOCK_CYCLES(LOCK_C), .CLOCK_FAIL_MONITOR_CYCLES(15)
    ) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h3),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .por_below(por_below), .bor_below(bor_below), .events(events), .sleep_entry(sleep_entry),
        .idle_entry(idle_entry), .fuses(fuses), .current_clock_select(current_clock_select),
        .fail_monitor_enable(1'b1), .osc_tick(osc_tick), .system_reset(system_reset),
        .clock_ready(clock_ready), .selected_clock(selected_clock), .fetch_address(fetch_address),
        .fetch_start(fetch_start), .watchdog_enable(watchdog_enable),
        .regulator_active_in_sleep(regulator_active_in_sleep),
        .clock_fail_monitor_active(clock_fail_monitor_active));
    supply_osc_model osc (.aclk(aclk), .power_cut(power_cut), .brown_cut(brown_cut),
        .tick_div(tick_div), .system_reset(system_reset), .por_below(por_below),
        .bor_below(bor_below), .osc_tick(osc_tick));
    always #10 aclk = ~aclk;
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic int exp_osc(input clock_mode_e m, input int div);
        int ost = (m inside {OSC_XT, OSC_HS, OSC_XTPLL, OSC_HSPLL}) ? 1024 * div : 0;
        return ost + ((m inside {OSC_FRCPLL, OSC_XTPLL, OSC_HSPLL, OSC_ECPLL}) ? LOCK_C : 0);
    endfunction : exp_osc
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        check(n < 100, 1'b1);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check(n < 100, 1'b1);
    endtask : axi_read
    // Cycles until reset drops and until the clock is ready, then a settle gap
    task automatic run_to_ready(output int t_rst, output int t_rdy);
        int n = 0;
        while (system_reset !== 1'b1 && n < 8) begin
            @(posedge aclk);
            n++;
        end
        check(system_reset, 1'b1);
        n = 0;
        while (system_reset !== 1'b0 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        t_rst = n;
        while (clock_ready !== 1'b1 && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        t_rdy = n;
        repeat (24) @(posedge aclk);
    endtask : run_to_ready
    initial begin
        int tr, ty, e;
        logic [31:0] rd;
        logic [1:0] rs;
        logic [15:0] d;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h00, rd, rs);
        check(rd, 32'h00000003);
        power_cut <= 1'b0;
        run_to_ready(tr, ty);
        check(selected_clock, OSC_HS);
        check(ty - tr >= 2047 && ty - tr <= 2054, 1'b1);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            d = (k == 0) ? 16'hffff : rnd;
            fuses.watchdog_fuse_enable <= k[0];
            axi_write(8'h00, d, rs);
            axi_read(8'h00, rd, rs);
            check(rd, {16'h0000, d & 16'hc3ff});
            check(system_reset, 1'b0);
            check(regulator_active_in_sleep, d[8]);
            check(watchdog_enable, d[5] | k[0]);
        end
        axi_write(8'h00, 16'h0000, rs);
        sleep_entry <= 1'b1;
        idle_entry <= 1'b1;
        @(posedge aclk);
        sleep_entry <= 1'b0;
        idle_entry <= 1'b0;
        axi_read(8'h00, rd, rs);
        check(rd, 32'h0000000c);
        axi_read(8'h04, rd, rs);
        check(rd[6], 1'b1);
        axi_read(8'h08, rd, rs);
        check(rd, 32'h0);
        check(rs, 2'b10);
        axi_write(8'h08, 16'hffff, rs);
        check(rs, 2'b10);
        // Each warm cause in turn, sweeping every clock mode, tick rate alternating 2 and 3
        for (int i = 0; i < 8; i++) begin
            tick_div <= 4'(2 + i % 2);
            current_clock_select <= clock_mode_e'(i);
            axi_write(8'h00, 16'h0000, rs);
            events <= reset_events_s'(6'h20 >> (i % 6));
            @(posedge aclk);
            events <= '0;
            run_to_ready(tr, ty);
            e = exp_osc(clock_mode_e'(i), 2 + i % 2);
            check(selected_clock, i);
            check(tr < 8, 1'b1);
            check(ty - tr >= e - 1 && ty - tr <= e + 7, 1'b1);
            axi_read(8'h00, rd, rs);
            check(rd, 32'h1 << flag_pos[i % 6]);
        end
        fuses.initial_clock_select_fuse <= OSC_ECPLL;
        axi_write(8'h00, 16'h0080, rs);
        brown_cut <= 1'b1;
        repeat (20) @(posedge aclk);
        brown_cut <= 1'b0;
        run_to_ready(tr, ty);
        check(selected_clock, OSC_ECPLL);
        check(tr >= 5000 + 4 * MS_C && tr <= 5010 + 4 * MS_C, 1'b1);
        axi_read(8'h00, rd, rs);
        check(rd, 32'h00000082);
        axi_write(8'h00, 16'hc3f0, rs);
        power_cut <= 1'b1;
        repeat (20) @(posedge aclk);
        power_cut <= 1'b0;
        run_to_ready(tr, ty);
        axi_read(8'h00, rd, rs);
        check(rd, 32'h00000003);
        print_verdict();
    end
    // Whole run needs about 31k cycles; this is a hang guard kept under 100k
    initial begin
        repeat (80000) @(posedge aclk);
        n_fail++;
        print_verdict();
    end
endmodule : reset_cause_and_startup_sequencer_tb
bind reset_cause_and_startup_sequencer rst_seq_assertions #(.CLOCK_FAIL_MONITOR_CYCLES(CLOCK_FAIL_MONITOR_CYCLES)) chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .bor_below(bor_below),
    .events(events), .fuses(fuses), .fail_monitor_enable(fail_monitor_enable),
    .system_reset(system_reset), .clock_ready(clock_ready), .fetch_address(fetch_address),
    .fetch_start(fetch_start), .watchdog_enable(watchdog_enable),
    .clock_fail_monitor_active(clock_fail_monitor_active));
`default_nettype wire
